// File: inc/irpt_defs.svh
// Purpose: offsets, field positions, reset values and sizes of the infrared pulse port
// Assumes: byte-wide register port, 12-bit byte address
// Notes: Contract below
// Contract
// RULE_01: clearing transmit FIFO enable empties it and zeroes every entry
// RULE_02: clearing receive FIFO enable empties it and zeroes every entry
// RULE_03: with carrier on transmit, a mark is a burst of edges, a space none
// RULE_04: with carrier strip on receive, edge series is a mark, silence a space
// RULE_05: trigger field picks edges: 00 off, 01 falling, 10 rising, 11 both
// RULE_06: each chosen edge ends the current width measurement and starts the next
// RULE_07: later carrier rises count only 16 receive clocks on, within the tolerance
// RULE_08: on timer overflow load all ones plus level, unless overflow load disabled
// RULE_09: loopback feeds modulator output to the receiver, pin still transmits
// RULE_10: carrier used: polarity 0 codes ones as marks, polarity 1 as spaces
// RULE_11: no carrier: polarity 0 ones high idle low, polarity 1 inverted idle high
// RULE_12: tx request: half full or less, or transmitter idle when source bit set
// RULE_13: rx request: half full or more, or not empty when source bit set
// RULE_14: transmitter and receiver run only while their enable bits are set
// RULE_15: 16-bit transmit divider counter reloads when either byte is written
// RULE_16: software never writes a zero transmit divider modulus
// RULE_17: 16-bit receive divider counter reloads when either byte is written
// RULE_18: software never writes a zero receive divider modulus
// RULE_19: duty value n gives n+1 high and 15-n low in each 16-clock carrier
// RULE_20: service requests readable as status; interrupt only where mask bit set
// RULE_21: on receive overrun keep entries, drop new widths, set overrun flag
// RULE_22: timeout flag sets at counter saturation, clears only with receiver enable
// RULE_23: data byte pair reads oldest receive entry, write pushes width and level
// RULE_24: low divider byte sits at the lower address of the 16-bit modulus
`ifndef IRPT_DEFS_SVH
`define IRPT_DEFS_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define IRPT_ADDR_W      12
`define IRPT_CTRL1_ADDR  12'h200
`define IRPT_CTRL2_ADDR  12'h201
`define IRPT_TDIVL_ADDR  12'h204
`define IRPT_TDIVH_ADDR  12'h205
`define IRPT_RDIVL_ADDR  12'h208
`define IRPT_RDIVH_ADDR  12'h209
`define IRPT_DUTY_ADDR   12'h20C
`define IRPT_STAT_ADDR   12'h210
`define IRPT_IEN_ADDR    12'h214
`define IRPT_FIFOL_ADDR  12'h23C
`define IRPT_FIFOH_ADDR  12'h23D
`define IRPT_LEVEL_ADDR  12'h23E
// ****************************************************************
// field positions and reset values
// ****************************************************************
`define IRPT_C1_TFE      7
`define IRPT_C1_RFE      6
`define IRPT_C1_MOD      5
`define IRPT_C1_DMD      4
`define IRPT_C2_OVFDIS   6
`define IRPT_C2_LOOP     5
`define IRPT_C2_CPL      4
`define IRPT_C2_TIC      3
`define IRPT_C2_RIC      2
`define IRPT_C2_TXE      1
`define IRPT_C2_RXE      0
`define IRPT_C2_MASK     8'h7F
`define IRPT_IEN_MASK    8'h33
`define IRPT_REG_RST     8'h00
// ****************************************************************
// sizes and timing
// ****************************************************************
`define IRPT_DEPTH       8
`define IRPT_CNT_W       4
`define IRPT_HALF        4'h4
`define IRPT_CARR_NOM    5'h10
`define IRPT_TOL_SMALL   5'h03
`define IRPT_TOL_BIG     5'h04
`define IRPT_WIDTH_MAX   16'hFFFF
`endif

// File: inc/irpt_pkg.sv
// Purpose: shared types of the infrared pulse port
// Assumes: nothing
// Notes: none
package irpt_pkg;
	typedef struct packed {
		logic        level;
		logic [15:0] width;
	} entry_type;

	typedef enum logic {
		TX_IDLE  = 1'b0,
		TX_PULSE = 1'b1
	} tx_state_type;
endpackage : irpt_pkg

// File: logic/irpt_fifo.sv
// Purpose: pulse entry FIFO with enable that clears every entry
// Assumes: push ignored when full, pop ignored when empty
// Notes: head shows the oldest entry
`timescale 1ns/1ns
`include "irpt_defs.svh"
module irpt_fifo (
	// clock and reset
	input  wire logic                      clock,
	input  wire logic                      rst,
	// control
	input  wire logic                      en,
	input  wire logic                      push,
	input  wire irpt_pkg::entry_type       push_data,
	input  wire logic                      pop,
	// state
	output irpt_pkg::entry_type            head,
	output logic [`IRPT_CNT_W-1:0]         count,
	output logic                           full,
	output logic                           empty
);
	logic [2:0]          wr_ptr_q;
	logic [2:0]          rd_ptr_q;
	logic [`IRPT_CNT_W-1:0] cnt_q;
	logic                do_push;
	logic                do_pop;
	irpt_pkg::entry_type slot [`IRPT_DEPTH];

	assign full    = (cnt_q == `IRPT_CNT_W'(`IRPT_DEPTH));
	assign empty   = (cnt_q == '0);
	assign count   = cnt_q;
	assign do_push = en && push && !full;
	assign do_pop  = en && pop && !empty;
	assign head    = slot[rd_ptr_q];

	// ****************************************************************
	// storage
	// ****************************************************************
	genvar i;
	generate
		for (i = 0; i < `IRPT_DEPTH; i++) begin : g_entry
			irpt_pkg::entry_type entry_q;
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					entry_q <= '0;
				end else if (!en) begin
					entry_q <= '0; // see RULE_01 see RULE_02
				end else if (do_push && wr_ptr_q == 3'(i)) begin
					entry_q <= push_data;
				end
			end
			assign slot[i] = entry_q;
		end
	endgenerate

	// ****************************************************************
	// pointers
	// ****************************************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else if (!en) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_q <= wr_ptr_q + 3'h1;
			end
			if (do_pop) begin
				rd_ptr_q <= rd_ptr_q + 3'h1;
			end
			cnt_q <= cnt_q + `IRPT_CNT_W'(do_push) - `IRPT_CNT_W'(do_pop);
		end
	end

	fifo_clear_a: assert property (@(posedge clock) disable iff (rst) // see RULE_01
		!en |=> (cnt_q == '0 && slot[0] == '0))
		else $error("fifo not cleared while disabled");
endmodule : irpt_fifo

// File: logic/irpt_top.sv
// Purpose: infrared pulse transmitter and receiver with byte register port
// Assumes: one 250 MHz clock; tx and rx clocks are enables from dividers
// Notes: rx pin passes a three-stage synchroniser
`timescale 1ns/1ns
`include "irpt_defs.svh"
module irpt_top (
	// clock and reset
	input  wire logic                    clock,
	input  wire logic                    rst,
	// register port
	input  wire logic [`IRPT_ADDR_W-1:0] addr,
	input  wire logic [7:0]              wr_data,
	input  wire logic                    wr_en,
	input  wire logic                    rd_en,
	output logic [7:0]                   rd_data,
	// requests
	output logic                         tx_service_req,
	output logic                         rx_service_req,
	output logic                         irq,
	// pins
	output logic                         infrared_output_pin,
	input  wire logic                    infrared_input_pin
);
	// ****************************************************************
	// registers
	// ****************************************************************
	logic [7:0]  ctrl1_q;
	logic [7:0]  ctrl2_q;
	logic [15:0] tdiv_q;
	logic [15:0] rdiv_q;
	logic [3:0]  duty_q;
	logic [7:0]  ien_q;
	logic [7:0]  stage_lo_q;
	logic        stage_lvl_q;
	logic [7:0]  rd_data_q;
	logic        ror_q;
	logic        rto_q;
	logic        tx_req_q;
	logic        rx_req_q;
	logic        irq_q;
	logic        ir_out_q;

	logic wr_tdl, wr_tdh, wr_rdl, wr_rdh, tx_push, rx_pop;
	assign wr_tdl  = wr_en && addr == `IRPT_TDIVL_ADDR;
	assign wr_tdh  = wr_en && addr == `IRPT_TDIVH_ADDR;
	assign wr_rdl  = wr_en && addr == `IRPT_RDIVL_ADDR;
	assign wr_rdh  = wr_en && addr == `IRPT_RDIVH_ADDR;
	assign tx_push = wr_en && addr == `IRPT_FIFOH_ADDR; // see RULE_23
	assign rx_pop  = rd_en && addr == `IRPT_FIFOH_ADDR; // see RULE_23

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl1_q     <= `IRPT_REG_RST;
			ctrl2_q     <= `IRPT_REG_RST; // see RULE_14
			tdiv_q      <= '0;
			rdiv_q      <= '0;
			duty_q      <= '0;
			ien_q       <= `IRPT_REG_RST;
			stage_lo_q  <= '0;
			stage_lvl_q <= 1'b0;
		end else if (wr_en) begin
			case (addr)
				`IRPT_CTRL1_ADDR: ctrl1_q     <= wr_data;
				`IRPT_CTRL2_ADDR: ctrl2_q     <= wr_data & `IRPT_C2_MASK;
				`IRPT_TDIVL_ADDR: tdiv_q[7:0]  <= wr_data; // see RULE_24
				`IRPT_TDIVH_ADDR: tdiv_q[15:8] <= wr_data;
				`IRPT_RDIVL_ADDR: rdiv_q[7:0]  <= wr_data;
				`IRPT_RDIVH_ADDR: rdiv_q[15:8] <= wr_data;
				`IRPT_DUTY_ADDR:  duty_q      <= wr_data[3:0];
				`IRPT_IEN_ADDR:   ien_q       <= wr_data & `IRPT_IEN_MASK;
				`IRPT_FIFOL_ADDR: stage_lo_q  <= wr_data;
				`IRPT_LEVEL_ADDR: stage_lvl_q <= wr_data[0];
				default: ;
			endcase
		end
	end

	logic transmit_fifo_enable, receive_fifo_enable, car_tx, car_rx, ovf_dis, loop, carrier_polarity, tx_service_source, rx_service_source, transmitter_enable, receiver_enable;
	assign transmit_fifo_enable     = ctrl1_q[`IRPT_C1_TFE];
	assign receive_fifo_enable     = ctrl1_q[`IRPT_C1_RFE];
	assign car_tx  = ctrl1_q[`IRPT_C1_MOD];
	assign car_rx  = ctrl1_q[`IRPT_C1_DMD];
	assign ovf_dis = ctrl2_q[`IRPT_C2_OVFDIS];
	assign loop    = ctrl2_q[`IRPT_C2_LOOP];
	assign carrier_polarity     = ctrl2_q[`IRPT_C2_CPL];
	assign tx_service_source     = ctrl2_q[`IRPT_C2_TIC];
	assign rx_service_source     = ctrl2_q[`IRPT_C2_RIC];
	assign transmitter_enable     = ctrl2_q[`IRPT_C2_TXE];
	assign receiver_enable     = ctrl2_q[`IRPT_C2_RXE];

	// ****************************************************************
	// clock dividers
	// ****************************************************************
	logic [15:0] tcnt_q;
	logic [15:0] rcnt_q;
	logic        tx_tick;
	logic        rx_tick;
	assign tx_tick = !(wr_tdl || wr_tdh) && tcnt_q <= 16'h0001;
	assign rx_tick = !(wr_rdl || wr_rdh) && rcnt_q <= 16'h0001;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tcnt_q <= '0;
		end else if (wr_tdl) begin
			tcnt_q <= {tdiv_q[15:8], wr_data}; // see RULE_15
		end else if (wr_tdh) begin
			tcnt_q <= {wr_data, tdiv_q[7:0]}; // see RULE_15
		end else if (tx_tick) begin
			tcnt_q <= tdiv_q;
		end else begin
			tcnt_q <= tcnt_q - 16'h0001;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rcnt_q <= '0;
		end else if (wr_rdl) begin
			rcnt_q <= {rdiv_q[15:8], wr_data}; // see RULE_17
		end else if (wr_rdh) begin
			rcnt_q <= {wr_data, rdiv_q[7:0]}; // see RULE_17
		end else if (rx_tick) begin
			rcnt_q <= rdiv_q;
		end else begin
			rcnt_q <= rcnt_q - 16'h0001;
		end
	end

	// ****************************************************************
	// transmitter
	// ****************************************************************
	irpt_pkg::entry_type    tx_head;
	irpt_pkg::entry_type    tx_in;
	irpt_pkg::tx_state_type tx_state_q;
	logic [`IRPT_CNT_W-1:0] tx_count;
	logic                   tx_empty;
	logic                   tx_pop;
	logic [15:0]            tx_rem_q;
	logic                   tx_lvl_q;
	logic [3:0]             phase_q;
	logic                   tx_last;
	logic                   mark;
	logic                   tx_mod;

	assign tx_in   = '{level: stage_lvl_q, width: {wr_data, stage_lo_q}};
	assign tx_last = tx_tick && tx_rem_q <= 16'h0001;
	assign tx_pop  = transmitter_enable && !tx_empty &&
		(tx_state_q == irpt_pkg::TX_IDLE && tx_tick || tx_last); // see RULE_14 see RULE_15

	irpt_fifo u_tx_fifo (
		.clock     (clock),
		.rst       (rst),
		.en        (transmit_fifo_enable),
		.push      (tx_push),
		.push_data (tx_in),
		.pop       (tx_pop),
		.head      (tx_head),
		.count     (tx_count),
		.full      (),
		.empty     (tx_empty)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_state_q <= irpt_pkg::TX_IDLE;
			tx_rem_q   <= '0;
			tx_lvl_q   <= 1'b0;
			phase_q    <= '0;
		end else if (!transmitter_enable) begin
			tx_state_q <= irpt_pkg::TX_IDLE; // see RULE_14
		end else if (tx_pop) begin
			tx_state_q <= irpt_pkg::TX_PULSE;
			tx_rem_q   <= tx_head.width;
			tx_lvl_q   <= tx_head.level;
			phase_q    <= '0;
		end else begin
			case (tx_state_q)
				irpt_pkg::TX_PULSE: begin
					if (tx_last) begin
						tx_state_q <= irpt_pkg::TX_IDLE;
					end else if (tx_tick) begin
						tx_rem_q <= tx_rem_q - 16'h0001;
						phase_q  <= phase_q + 4'h1;
					end
				end
				default: tx_state_q <= irpt_pkg::TX_IDLE;
			endcase
		end
	end

	assign mark = tx_lvl_q ^ carrier_polarity; // see RULE_10 see RULE_11
	always_comb begin
		if (tx_state_q == irpt_pkg::TX_IDLE) begin
			tx_mod = car_tx ? 1'b0 : carrier_polarity; // see RULE_11
		end else if (car_tx) begin
			tx_mod = mark && (phase_q <= duty_q); // see RULE_03 see RULE_19
		end else begin
			tx_mod = mark; // see RULE_03
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ir_out_q <= 1'b0;
		end else begin
			ir_out_q <= tx_mod; // see RULE_09
		end
	end

	// ****************************************************************
	// receive input and carrier strip
	// ****************************************************************
	logic [2:0] sync_q;
	logic       pin_q;
	logic       src;
	logic       src_prev_q;
	logic       carr_q;
	logic [4:0] gap_q;
	logic [4:0] lo_lim;
	logic [4:0] hi_lim;
	logic       src_rise;
	logic       lvl;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_q <= '0;
			pin_q  <= 1'b0;
		end else begin
			sync_q <= {sync_q[1:0], infrared_input_pin};
			if (sync_q[1] == sync_q[2]) begin
				pin_q <= sync_q[2];
			end
		end
	end

	assign src      = loop ? tx_mod : pin_q; // see RULE_09
	assign src_rise = src && !src_prev_q;
	assign lo_lim   = `IRPT_CARR_NOM - (ctrl1_q[0] ? `IRPT_TOL_BIG : `IRPT_TOL_SMALL);
	assign hi_lim   = `IRPT_CARR_NOM + (ctrl1_q[1] ? `IRPT_TOL_BIG : `IRPT_TOL_SMALL);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			src_prev_q <= 1'b0;
			carr_q     <= 1'b0;
			gap_q      <= '0;
		end else if (!receiver_enable) begin
			src_prev_q <= src;
			carr_q     <= 1'b0;
			gap_q      <= '0;
		end else begin
			src_prev_q <= src;
			if (src_rise && (!carr_q || (gap_q >= lo_lim && gap_q <= hi_lim))) begin
				carr_q <= 1'b1; // see RULE_07
				gap_q  <= '0;
			end else if (rx_tick && carr_q) begin
				if (gap_q > hi_lim) begin
					carr_q <= 1'b0; // see RULE_04
				end else begin
					gap_q <= gap_q + 5'h01;
				end
			end
		end
	end

	assign lvl = car_rx ? carr_q : src; // see RULE_04

	// ****************************************************************
	// pulse timer
	// ****************************************************************
	irpt_pkg::entry_type    rx_head;
	irpt_pkg::entry_type    rx_in;
	logic [`IRPT_CNT_W-1:0] rx_count;
	logic                   rx_full;
	logic                   rx_empty;
	logic                   lvl_prev_q;
	logic [15:0]            timer_q;
	logic                   rx_busy_q;
	logic                   edge_hit;
	logic                   sat_hit;
	logic                   rx_push;

	always_comb begin
		case (ctrl1_q[3:2])
			2'b01:   edge_hit = lvl_prev_q && !lvl; // see RULE_05
			2'b10:   edge_hit = !lvl_prev_q && lvl;
			2'b11:   edge_hit = lvl_prev_q != lvl;
			default: edge_hit = 1'b0;
		endcase
	end

	assign sat_hit = rx_busy_q && rx_tick && timer_q == `IRPT_WIDTH_MAX - 16'h0001;
	assign rx_push = receiver_enable && (edge_hit && rx_busy_q || sat_hit && !ovf_dis); // see RULE_08
	assign rx_in   = '{level: lvl_prev_q, width: sat_hit ? `IRPT_WIDTH_MAX : timer_q};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lvl_prev_q <= 1'b0;
			timer_q    <= '0;
			rx_busy_q  <= 1'b0;
		end else if (!receiver_enable) begin
			lvl_prev_q <= lvl;
			timer_q    <= '0;
			rx_busy_q  <= 1'b0; // see RULE_14
		end else begin
			lvl_prev_q <= lvl;
			if (edge_hit) begin
				timer_q   <= '0; // see RULE_06
				rx_busy_q <= 1'b1;
			end else if (rx_busy_q && rx_tick && timer_q != `IRPT_WIDTH_MAX) begin
				timer_q <= timer_q + 16'h0001;
			end
		end
	end

	irpt_fifo u_rx_fifo (
		.clock     (clock),
		.rst       (rst),
		.en        (receive_fifo_enable),
		.push      (rx_push),
		.push_data (rx_in),
		.pop       (rx_pop),
		.head      (rx_head),
		.count     (rx_count),
		.full      (rx_full),
		.empty     (rx_empty)
	);

	// ****************************************************************
	// flags, requests and read port
	// ****************************************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ror_q <= 1'b0;
			rto_q <= 1'b0;
		end else begin
			if (rx_push && rx_full) begin
				ror_q <= 1'b1; // see RULE_21
			end else if (!receive_fifo_enable) begin
				ror_q <= 1'b0;
			end
			if (sat_hit) begin
				rto_q <= 1'b1; // see RULE_22
			end else if (!receiver_enable) begin
				rto_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_req_q <= 1'b0;
			rx_req_q <= 1'b0;
			irq_q    <= 1'b0;
		end else begin
			tx_req_q <= tx_service_source ? tx_state_q == irpt_pkg::TX_IDLE : tx_count <= `IRPT_HALF; // see RULE_12
			rx_req_q <= rx_service_source ? !rx_empty : rx_count >= `IRPT_HALF; // see RULE_13
			irq_q    <= |({2'b00, tx_req_q, rx_req_q, 2'b00, ror_q, rto_q} & ien_q); // see RULE_20
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_data_q <= '0;
		end else if (rd_en) begin
			case (addr)
				`IRPT_CTRL1_ADDR: rd_data_q <= ctrl1_q;
				`IRPT_CTRL2_ADDR: rd_data_q <= ctrl2_q;
				`IRPT_TDIVL_ADDR: rd_data_q <= tdiv_q[7:0];
				`IRPT_TDIVH_ADDR: rd_data_q <= tdiv_q[15:8];
				`IRPT_RDIVL_ADDR: rd_data_q <= rdiv_q[7:0];
				`IRPT_RDIVH_ADDR: rd_data_q <= rdiv_q[15:8];
				`IRPT_DUTY_ADDR:  rd_data_q <= {4'h0, duty_q};
				`IRPT_STAT_ADDR:  rd_data_q <= {2'b00, tx_req_q, rx_req_q,
					tx_state_q == irpt_pkg::TX_PULSE, rx_busy_q, ror_q, rto_q}; // see RULE_20
				`IRPT_IEN_ADDR:   rd_data_q <= ien_q;
				`IRPT_FIFOL_ADDR: rd_data_q <= rx_head.width[7:0]; // see RULE_23
				`IRPT_FIFOH_ADDR: rd_data_q <= rx_head.width[15:8];
				`IRPT_LEVEL_ADDR: rd_data_q <= {6'h00, !rx_empty, rx_head.level};
				default:          rd_data_q <= 8'h00;
			endcase
		end else begin
			rd_data_q <= 8'h00;
		end
	end

	assign rd_data             = rd_data_q;
	assign tx_service_req      = tx_req_q;
	assign rx_service_req      = rx_req_q;
	assign irq                 = irq_q;
	assign infrared_output_pin = ir_out_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_tdiv_write;
		wr_tdl || wr_tdh;
	endsequence

	tdiv_reload_a: assert property (s_tdiv_write |=> tcnt_q == tdiv_q) // see RULE_15
		else $error("tx divider not reloaded");
	tx_idle_level_a: assert property ( // see RULE_11
		(tx_state_q == irpt_pkg::TX_IDLE && !car_tx) |=> ir_out_q == $past(carrier_polarity))
		else $error("idle output level wrong");
	tx_enable_a: assert property (!transmitter_enable |=> tx_state_q == irpt_pkg::TX_IDLE) // see RULE_14
		else $error("transmitter runs while disabled");
	tx_request_a: assert property (!tx_service_source && tx_count <= `IRPT_HALF |=> tx_req_q) // see RULE_12
		else $error("tx request missing");
	rx_request_a: assert property (rx_service_source && !rx_empty |=> rx_req_q) // see RULE_13
		else $error("rx request missing");
	irq_gate_a: assert property (ien_q == 8'h00 |=> !irq_q) // see RULE_20
		else $error("interrupt without mask");
	overrun_flag_a: assert property (rx_push && rx_full |=> ror_q && // see RULE_21
		rx_count == $past(rx_count) - {3'b000, $past(rx_pop)})
		else $error("overrun not flagged");
	timeout_hold_a: assert property (rto_q && receiver_enable |=> rto_q) // see RULE_22
		else $error("timeout flag dropped");
	carrier_duty_a: assert property ( // see RULE_19
		tx_state_q == irpt_pkg::TX_PULSE && car_tx && mark && phase_q > duty_q |-> !tx_mod)
		else $error("carrier high past duty");
endmodule : irpt_top

// File: test/irpt_ir_model.sv
// Purpose: emitter and photo-receiver beside the infrared pins
// Assumes: receiver output follows the scene one clock late
// Notes: counts lit emitter cycles
`timescale 1ns/1ns
module irpt_ir_model (
	// clock
	input  wire logic  clock,
	// emitter side
	input  wire logic  led,
	input  wire logic  clr,
	output logic [15:0] lit,
	// receiver side
	input  wire logic  scene,
	output logic       rx_pin
);
	always @(posedge clock) begin
		rx_pin <= scene;
		lit    <= clr ? 16'h0000 : lit + {15'h0000, led};
	end
endmodule : irpt_ir_model

// File: test/irpt_top_tb.sv
// Purpose: self-checking bench of the infrared pulse port
// Assumes: divider moduli kept small
// Notes: lit counts come from the emitter model
`timescale 1ns/1ns
`include "irpt_defs.svh"
module irpt_top_tb;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] addr = 12'h000;
	logic [7:0]  wr_data = 8'h00;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic        scene = 1'b0;
	logic        clr = 1'b1;
	logic [7:0]  rd_data, d;
	logic        tx_req, rx_req, irq, led, rx_pin;
	logic [15:0] lit;
	int          bad_count = 0;
	int          n_tests = 0;
	logic [11:0] regs [9] = '{12'h200, 12'h201, 12'h204, 12'h205, 12'h208,
		12'h209, 12'h20C, 12'h214, 12'h2FF};
	logic [7:0]  wmask [9] = '{8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h33, 8'h00};
	logic [7:0]  rx_exp [4] = '{8'h00, 8'h00, 8'h01, 8'h02};
	logic [3:0]  duty [3] = '{4'h0, 4'h3, 4'hF};
	always #2 clock = ~clock;
	irpt_top irpt_top_i (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .tx_service_req(tx_req),
		.rx_service_req(rx_req), .irq(irq), .infrared_output_pin(led),
		.infrared_input_pin(rx_pin));
	irpt_ir_model irpt_ir_model_i (.clock(clock), .led(led), .clr(clr), .lit(lit),
		.scene(scene), .rx_pin(rx_pin));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clock);
		addr    <= a;
		wr_data <= v;
		wr_en   <= 1'b1;
		@(posedge clock);
		wr_en   <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge clock);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask : rd
	task automatic push(input logic lvl, input logic [15:0] w);
		wr(`IRPT_FIFOL_ADDR, w[7:0]);
		wr(`IRPT_LEVEL_ADDR, {7'h00, lvl});
		wr(`IRPT_FIFOH_ADDR, w[15:8]);
	endtask : push
	task automatic tx_pulse(input logic lvl, input logic [15:0] w, input logic [15:0] exp);
		clr <= 1'b1;
		push(lvl, w);
		clr <= 1'b0;
		repeat (3 * w + 40) @(posedge clock);
		chk("lit cycles", lit, exp);
	endtask : tx_pulse
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic s_regs();
		for (int i = 0; i < 9; i++) begin
			rd(regs[i]);
			chk("reset value", {8'h00, d}, 16'h0000);
		end
		for (int i = 0; i < 9; i++)
			wr(regs[i], 8'hFF);
		for (int i = 0; i < 9; i++) begin
			rd(regs[i]);
			chk("readback", {8'h00, d}, {8'h00, wmask[i]});
		end
		for (int i = 0; i < 9; i++)
			wr(regs[i], (i == 2 || i == 4) ? 8'h01 : 8'h00);
	endtask : s_regs
	task automatic s_tx_level();
		wr(`IRPT_TDIVL_ADDR, 8'h01);
		wr(`IRPT_CTRL1_ADDR, 8'h80);
		tx_pulse(1'b1, 16'd20, 16'd0);
		wr(`IRPT_CTRL1_ADDR, 8'h00);
		wr(`IRPT_CTRL1_ADDR, 8'h80);
		wr(`IRPT_CTRL2_ADDR, 8'h02);
		tx_pulse(1'b1, 16'd20, 16'd20);
		wr(`IRPT_TDIVL_ADDR, 8'h03);
		tx_pulse(1'b1, 16'd5, 16'd15);
		chk("idle low", led, 1'b0);
		wr(`IRPT_CTRL2_ADDR, 8'h12);
		repeat (4) @(posedge clock);
		chk("idle high", led, 1'b1);
		wr(`IRPT_CTRL2_ADDR, 8'h02);
	endtask : s_tx_level
	task automatic s_carrier();
		wr(`IRPT_TDIVL_ADDR, 8'h01);
		wr(`IRPT_CTRL1_ADDR, 8'hA0);
		for (int i = 0; i < 3; i++) begin
			wr(`IRPT_DUTY_ADDR, {4'h0, duty[i]});
			tx_pulse(1'b1, 16'd32, {10'h000, duty[i] + 5'h01, 1'b0});
			tx_pulse(1'b0, 16'd32, 16'd0);
		end
	endtask : s_carrier
	task automatic s_tx_req();
		wr(`IRPT_CTRL2_ADDR, 8'h00);
		wr(`IRPT_CTRL1_ADDR, 8'h80);
		repeat (3) @(posedge clock);
		chk("tx request empty", tx_req, 1'b1);
		for (int i = 0; i < 5; i++)
			push(1'b1, 16'd100);
		repeat (3) @(posedge clock);
		chk("tx request five", tx_req, 1'b0);
		wr(`IRPT_CTRL1_ADDR, 8'h00);
		repeat (3) @(posedge clock);
		chk("tx request cleared", tx_req, 1'b1);
		wr(`IRPT_CTRL2_ADDR, 8'h08);
		wr(`IRPT_CTRL1_ADDR, 8'h80);
		wr(`IRPT_CTRL2_ADDR, 8'h0A);
		push(1'b1, 16'd100);
		repeat (3) @(posedge clock);
		chk("tx request busy", tx_req, 1'b0);
		rd(`IRPT_STAT_ADDR);
		chk("status busy", {8'h00, d & 8'h28}, 16'h0008);
		repeat (120) @(posedge clock);
		chk("tx request idle", tx_req, 1'b1);
		wr(`IRPT_CTRL2_ADDR, 8'h00);
	endtask : s_tx_req
	task automatic s_rx();
		logic [7:0] n;
		wr(`IRPT_RDIVL_ADDR, 8'h01);
		for (int c = 0; c < 4; c++) begin
			wr(`IRPT_CTRL2_ADDR, 8'h00);
			wr(`IRPT_CTRL1_ADDR, 8'h00);
			scene <= 1'b0;
			repeat (10) @(posedge clock);
			wr(`IRPT_CTRL1_ADDR, {4'h4, c[1:0], 2'b00});
			wr(`IRPT_CTRL2_ADDR, 8'h05);
			repeat (3) begin
				scene <= ~scene;
				repeat (40) @(posedge clock);
			end
			wr(`IRPT_IEN_ADDR, 8'h10);
			repeat (3) @(posedge clock);
			chk("rx request", rx_req, rx_exp[c] != 0);
			chk("irq", irq, rx_exp[c] != 0);
			n = 8'h00;
			for (int k = 0; k < 8; k++) begin
				rd(`IRPT_LEVEL_ADDR);
				if (d[1]) begin
					rd(`IRPT_FIFOH_ADDR);
					n++;
				end
			end
			chk("entries", n, rx_exp[c]);
		end
		wr(`IRPT_IEN_ADDR, 8'h00);
	endtask : s_rx
	task automatic s_loop();
		scene <= 1'b0;
		wr(`IRPT_CTRL2_ADDR, 8'h00);
		wr(`IRPT_CTRL1_ADDR, 8'h00);
		wr(`IRPT_CTRL1_ADDR, 8'hCC);
		wr(`IRPT_CTRL2_ADDR, 8'h27);
		scene <= 1'b1;
		tx_pulse(1'b1, 16'd20, 16'd20);
		chk("loop request", rx_req, 1'b1);
		rd(`IRPT_FIFOH_ADDR);
		rd(`IRPT_LEVEL_ADDR);
		chk("loop one entry", d[1], 1'b0);
		wr(`IRPT_CTRL2_ADDR, 8'h26);
		wr(`IRPT_CTRL1_ADDR, 8'hFC);
		wr(`IRPT_DUTY_ADDR, 8'h03);
		wr(`IRPT_CTRL2_ADDR, 8'h27);
		tx_pulse(1'b1, 16'd64, 16'd16);
		rd(`IRPT_FIFOH_ADDR);
		rd(`IRPT_LEVEL_ADDR);
		chk("strip one entry", d[1], 1'b0);
		wr(`IRPT_CTRL1_ADDR, 8'hCC);
		for (int i = 0; i < 5; i++)
			push(1'b1, 16'd2);
		repeat (10) @(posedge clock);
		rd(`IRPT_STAT_ADDR);
		chk("overrun", {8'h00, d & 8'h02}, 16'h0002);
	endtask : s_loop
	initial begin
		#80000;
		bad_count++;
		results();
	end
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		s_regs();
		s_tx_level();
		s_carrier();
		s_tx_req();
		s_rx();
		s_loop();
		results();
	end
endmodule : irpt_top_tb
